//--- bench/hardware_option_loader_tb_top.sv
`timescale 1ns/1ps
module hardware_option_loader_tb_top
  import hw_option_pkg::*;
;
  typedef struct packed {
    logic [23:0] w;
    logic        er, por, bo, boot;
    logic [15:0] ls, lb;
    logic [1:0]  bod;
    logic [7:0]  wd;
  } row_type;
  row_type                  rows [6];
  logic                     clk = 0, rst_b = 0, hsel = 0, hwrite = 0, por = 0, bo = 0, d1 = 0, d2 = 0, erin = 0;
  logic                     ovf = 0;
  logic [1:0]               htrans = 2'h0;
  logic [31:0]              haddr = 32'h0, hwdata = 32'h0;
  logic [7:0]               raw = 8'h5a;
  logic [23:0]              win = 24'h0;
  logic [3:0]               dly = 4'h0;
  wire                      hready, hresp, req, ack, erased, hold, boot, breq, dpe;
  wire [31:0]               hrdata;
  wire [23:0]               data;
  wire [7:0]                pgm;
  wire [15:0]               bsa, lsa, lb;
  wire [1:0]                bodl;
  watchdog_control_reg_type wcr;
  integer                   n_fail = 0, checked = 0;

  always #25 clk = ~clk;

  hardware_option_loader u_dut (
    .CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp),
    .NVM_RD_REQ(req), .NVM_RD_ACK(ack), .NVM_RD_DATA(data), .NVM_ERASED(erased),
    .POWERUP_RESET(por), .BROWNOUT_RESET_CAUSE(bo), .PGM_READ_RAW(raw), .PGM_READ_DATA(pgm),
    .BROWNOUT_DETECTOR_FIRST(d1), .BROWNOUT_DETECTOR_SECOND(d2), .WDOG_OVERFLOW(ovf),
    .CPU_HOLD(hold), .BOOT_FROM_LOADER(boot), .BOOT_START_ADDR(bsa), .LOADER_START_ADDR(lsa),
    .APP_PROG_LOWER_BOUND(lb), .BOD_SECOND_LEVEL(bodl), .BROWNOUT_RESET_REQ(breq),
    .WATCHDOG_CONTROL_REG(wcr), .DEBUG_PIN_ENABLE(dpe));

  option_store_model u_store (.clk(clk), .rst_b(rst_b), .req(req), .dly(dly), .word_in(win),
    .erased_in(erin), .ack(ack), .data(data), .erased(erased));

  task automatic test_done();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // the slave's wait states are not assumed, only bounded
  task automatic wt();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) chk("hreadyout", 1, hready);
  endtask : wt

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wt();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    @(posedge clk);
  endtask : wr

  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask : rchk

  task automatic load(input row_type r, input logic [3:0] d);
    int k;
    rst_b <= 1'b0;
    win   <= r.w;
    erin  <= r.er;
    por   <= r.por;
    bo    <= r.bo;
    dly   <= d;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("cpu_hold", 1, hold);
    k = 0;
    while (hold !== 1'b0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk("load_done", 0, hold);
  endtask : load

  initial begin
    rows[0] = {24'hffffff, 4'b1000, 16'h8000, 16'h8000, 2'h0, 8'h00};
    rows[1] = {24'h494000, 4'b0101, 16'h7600, 16'h6c00, 2'h0, 8'h00};
    rows[2] = {24'h782380, 4'b0000, 16'h7000, 16'h7000, 2'h2, 8'h30};
    rows[3] = {24'h97f4ec, 4'b0101, 16'h7c00, 16'h5e00, 2'h3, 8'h4d};
    rows[4] = {24'h0c9000, 4'b0100, 16'h8000, 16'h7c00, 2'h1, 8'h00};
    rows[5] = {24'h440000, 4'b0110, 16'h7600, 16'h7600, 2'h0, 8'h00};
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      load(rows[i], i[3:0]);
      chk("boot", rows[i].boot, boot);
      chk("boot_addr", rows[i].boot ? rows[i].ls : APP_START_ADDR, bsa);
      chk("loader_start", rows[i].ls, lsa);
      chk("app_bound", rows[i].lb, lb);
      chk("bod_level", rows[i].bod, bodl);
      chk("wdog", rows[i].wd, wcr);
      $display("row %0d done", i);
    end
    // locked, write-protected options
    load(rows[3], 4'h2);
    wr(OFFS_WDOG_CTRL, 32'h3f);
    rchk("wdog_protected", OFFS_WDOG_CTRL, 32'h4d);
    wr(OFFS_OPTION_STATUS, 32'h0);
    chk("hresp", 0, hresp);
    rchk("option_status", OFFS_OPTION_STATUS, {8'h00, rows[3].w});
    rchk("unmapped", 32'h20, 32'h0);
    chk("pgm_locked", PROG_LOCK_VALUE, pgm);
    d1 <= 1'b1;
    repeat (5) @(posedge clk);
    chk("bod_first_off", 0, breq);
    d1 <= 1'b0;
    d2 <= 1'b1;
    repeat (5) @(posedge clk);
    chk("bod_second_on", 1, breq);
    d2 <= 1'b0;
    wr(OFFS_POWER_CONTROL_THREE, 32'h0);
    chk("debug_off", 0, dpe);
    $display("locked case done");
    // factory region sizes with power-up boot select set, nothing protected
    load(rows[1], 4'h6);
    chk("debug_reset", 1, dpe);
    wr(OFFS_POWER_CONTROL_THREE, 32'h0);
    rchk("debug_clear", OFFS_POWER_CONTROL_THREE, 32'h0);
    wr(OFFS_POWER_CONTROL_THREE, 32'h1);
    chk("debug_set", 1, dpe);
    wr(OFFS_WDOG_CTRL, 32'h3a);
    rchk("wdog_free", OFFS_WDOG_CTRL, 32'h3a);
    chk("wdog_port", 8'h3a, wcr);
    // overflow held through the clearing write, so the set must win
    ovf <= 1'b1;
    wr(OFFS_WDOG_CTRL, 32'h3a);
    ovf <= 1'b0;
    rchk("wdog_flag_kept", OFFS_WDOG_CTRL, 32'hba);
    wr(OFFS_WDOG_CTRL, 32'h3a);
    rchk("wdog_flag_clear", OFFS_WDOG_CTRL, 32'h3a);
    wr(OFFS_APP_PROG_LOWER_BOUND, 32'h1234);
    rchk("app_bound_sw", OFFS_APP_PROG_LOWER_BOUND, 32'h1234);
    chk("app_bound_port", 16'h1234, lb);
    chk("pgm_open", 8'h5a, pgm);
    d2 <= 1'b1;
    repeat (5) @(posedge clk);
    chk("bod_second_off", 0, breq);
    $display("factory case done");
    test_done();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : hardware_option_loader_tb_top

//--- bench/option_store_model.sv
`timescale 1ns/1ps
module option_store_model
  import hw_option_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    req,
  input  wire logic [3:0]              dly,
  input  wire logic [OPTION_WIDTH-1:0] word_in,
  input  wire logic                    erased_in,
  output logic                         ack,
  output logic [OPTION_WIDTH-1:0]      data,
  output logic                         erased
);
  logic [3:0]              cnt_q;
  logic [OPTION_WIDTH-1:0] pat_q;
  // stored word is only replaced by the bench while reset is held low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      ack   <= 1'b0;
      pat_q <= ~word_in;
    end else begin
      pat_q <= {pat_q[OPTION_WIDTH-2:0], ~pat_q[OPTION_WIDTH-1]};
      ack   <= req && !ack && cnt_q >= dly;
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
    end
  end
  // outside the ack cycle the lines walk, so a stale sample never looks right
  assign data   = ack ? word_in : pat_q;
  assign erased = ack ? erased_in : ~erased_in;
endmodule : option_store_model

//--- common/hw_option_pkg.sv
package hw_option_pkg;

  localparam int          OPTION_WIDTH   = 24;
  localparam int          HALF_K_SHIFT   = 9;
  localparam logic [15:0] FLASH_END_ADDR = 16'h7fff;
  localparam logic [15:0] APP_START_ADDR = 16'h0000;
  localparam logic [7:0]  PROG_LOCK_VALUE = 8'hff;

  // register byte offsets on the bus
  localparam logic [31:0] OFFS_OPTION_STATUS        = 32'h0000_0000;
  localparam logic [31:0] OFFS_WDOG_CTRL            = 32'h0000_0004;
  localparam logic [31:0] OFFS_POWER_CONTROL_THREE  = 32'h0000_0008;
  localparam logic [31:0] OFFS_APP_PROG_LOWER_BOUND = 32'h0000_000c;
  localparam logic [31:0] OFFS_BOOT_STATUS          = 32'h0000_0010;

  localparam int          DEBUG_PIN_ENABLE_BIT   = 0;
  localparam logic        DEBUG_PIN_ENABLE_RESET = 1'b1;
  localparam logic [2:0]  LOADER_SIZE_NONE       = 3'h0;
  localparam logic [2:0]  LOADER_SIZE_2K5        = 3'h4;
  localparam logic [3:0]  APP_SIZE_2K5           = 4'h5;

  typedef struct packed {
    logic       lock;
    logic [2:0] loader_size;
    logic       powerup_boot_select;
    logic       anyreset_boot_select;
    logic [3:0] app_prog_size;
    logic       bod_level_sel_hi;
    logic       bod_level_sel_lo;
    logic       first_brownout_reset_en;
    logic       second_brownout_reset_en;
    logic       wdog_reset_option;
    logic       wdog_nonstop_option;
    logic       wdog_autostart_option;
    logic       wdog_idle_option;
    logic       wdog_prescale_opt2;
    logic       wdog_prescale_opt1;
    logic       wdog_prescale_opt0;
    logic       wdog_write_protect_option;
    logic [1:0] spare;
  } option_type;

  typedef struct packed {
    logic       wdog_overflow_flag;
    logic       wdog_enable;
    logic       wdog_reset_enable;
    logic       wdog_nonstop;
    logic       wdog_idle_count;
    logic [2:0] wdog_prescale;
  } watchdog_control_reg_type;

  localparam option_type FACTORY_OPTIONS = '{loader_size: LOADER_SIZE_2K5, app_prog_size: APP_SIZE_2K5,
                                             default: '0};
  localparam watchdog_control_reg_type WDOG_CTRL_RESET = '0;

  typedef enum {FETCH_REQ, FETCH_WAIT, FETCH_DONE} fetch_state_type;

endpackage : hw_option_pkg

//--- core/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bit_sync

//--- core/hardware_option_loader.sv
`timescale 1ns/1ps
module hardware_option_loader
  import hw_option_pkg::*;
(
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  input  wire logic                    HSEL,
  input  wire logic [31:0]             HADDR,
  input  wire logic [1:0]              HTRANS,
  input  wire logic                    HWRITE,
  input  wire logic [2:0]              HSIZE,
  input  wire logic [31:0]             HWDATA,
  input  wire logic                    HREADY,
  output logic                         HREADYOUT,
  output logic [31:0]                  HRDATA,
  output logic                         HRESP,
  output logic                         NVM_RD_REQ,
  input  wire logic                    NVM_RD_ACK,
  input  wire logic [OPTION_WIDTH-1:0] NVM_RD_DATA,
  input  wire logic                    NVM_ERASED,
  input  wire logic                    POWERUP_RESET,
  input  wire logic                    BROWNOUT_RESET_CAUSE,
  input  wire logic [7:0]              PGM_READ_RAW,
  output logic [7:0]                   PGM_READ_DATA,
  input  wire logic                    BROWNOUT_DETECTOR_FIRST,
  input  wire logic                    BROWNOUT_DETECTOR_SECOND,
  input  wire logic                    WDOG_OVERFLOW,
  output logic                         CPU_HOLD,
  output logic                         BOOT_FROM_LOADER,
  output logic [15:0]                  BOOT_START_ADDR,
  output logic [15:0]                  LOADER_START_ADDR,
  output logic [15:0]                  APP_PROG_LOWER_BOUND,
  output logic [1:0]                   BOD_SECOND_LEVEL,
  output logic                         BROWNOUT_RESET_REQ,
  output watchdog_control_reg_type     WATCHDOG_CONTROL_REG,
  output logic                         DEBUG_PIN_ENABLE
);
  option_type               fetch_word;
  logic                     fetch_valid;
  logic [1:0]               bod_sync;
  logic                     load_en;

  logic                     load_done_q, load_done_d;
  logic                     por_q, por_d;
  option_type               opt_q, opt_d;
  logic                     boot_q, boot_d;
  logic [15:0]              boot_addr_q, boot_addr_d;
  logic [15:0]              loader_start_q, loader_start_d;
  logic [15:0]              app_lb_q, app_lb_d;
  watchdog_control_reg_type wdog_q, wdog_d;
  logic                     debug_q, debug_d;
  logic                     bod_req_q, bod_req_d;
  logic [7:0]               prog_q, prog_d;

  logic                     wr_phase_q, wr_phase_d;
  logic                     rd_phase_q, rd_phase_d;
  logic [31:0]              addr_q, addr_d;
  logic [31:0]              hrdata_q, hrdata_d;
  logic [31:0]              rd_value;
  logic                     reg_write;
  logic [15:0]              new_loader_start;
  logic [3:0]               loader_halves;
  logic                     loader_exists;

  option_fetch u_fetch (
    .clk         (CLK),
    .rst_b       (RST_B),
    .nvm_rd_ack  (NVM_RD_ACK),
    .nvm_rd_data (NVM_RD_DATA),
    .nvm_erased  (NVM_ERASED),
    .nvm_rd_req  (NVM_RD_REQ),
    .word_valid  (fetch_valid),
    .word        (fetch_word)
  );

  // detector outputs are analog-side levels, so they are synchronised first
  bit_sync #(.WIDTH(2)) u_bod_sync (
    .clk      (CLK),
    .rst_b    (RST_B),
    .async_in ({BROWNOUT_DETECTOR_SECOND, BROWNOUT_DETECTOR_FIRST}),
    .sync_out (bod_sync)
  );

  function automatic logic [15:0] region_base(input logic [15:0] top, input logic [3:0] halves);
    region_base = top - 16'({12'h000, halves} << HALF_K_SHIFT);
  endfunction : region_base

  assign load_en       = fetch_valid && !load_done_q;
  // size code n stands for n+1 half-K blocks, 1K up to 4K
  assign loader_exists = (fetch_word.loader_size != LOADER_SIZE_NONE);
  // widen before adding so the 4K code does not wrap to zero
  assign loader_halves = loader_exists ? ({1'b0, fetch_word.loader_size} + 4'h1) : 4'h0;
  assign new_loader_start = region_base(FLASH_END_ADDR + 16'h0001, loader_halves);

  // option holding latches, boot decision and region bounds
  always_comb begin
    load_done_d    = load_done_q;
    por_d          = por_q;
    opt_d          = opt_q;
    boot_d         = boot_q;
    boot_addr_d    = boot_addr_q;
    loader_start_d = loader_start_q;
    app_lb_d       = app_lb_q;
    if (load_en) begin
      load_done_d    = 1'b1;
      por_d          = POWERUP_RESET;
      opt_d          = fetch_word;
      loader_start_d = new_loader_start;
      app_lb_d       = region_base(new_loader_start, fetch_word.app_prog_size);
      // brown-out resets always restart at the application start
      boot_d = loader_exists && !BROWNOUT_RESET_CAUSE &&
               (fetch_word.anyreset_boot_select || (fetch_word.powerup_boot_select && POWERUP_RESET));
      boot_addr_d = boot_d ? new_loader_start : APP_START_ADDR;
    end else if (reg_write && addr_q == OFFS_APP_PROG_LOWER_BOUND) begin
      app_lb_d = HWDATA[15:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      load_done_q    <= 1'b0;
      por_q          <= 1'b0;
      opt_q          <= FACTORY_OPTIONS;
      boot_q         <= 1'b0;
      boot_addr_q    <= APP_START_ADDR;
      loader_start_q <= FLASH_END_ADDR + 16'h0001;
      app_lb_q       <= FLASH_END_ADDR + 16'h0001;
    end else begin
      load_done_q    <= load_done_d;
      por_q          <= por_d;
      opt_q          <= opt_d;
      boot_q         <= boot_d;
      boot_addr_q    <= boot_addr_d;
      loader_start_q <= loader_start_d;
      app_lb_q       <= app_lb_d;
    end
  end

  // watchdog control, debug pin switch, brown-out requests, programmer read path
  always_comb begin
    wdog_d    = wdog_q;
    debug_d   = debug_q;
    bod_req_d = load_done_q &&
                ((bod_sync[0] && opt_q.first_brownout_reset_en) ||
                 (bod_sync[1] && opt_q.second_brownout_reset_en));
    prog_d    = opt_q.lock ? PROG_LOCK_VALUE : PGM_READ_RAW;
    if (load_en) begin
      wdog_d.wdog_reset_enable = fetch_word.wdog_reset_option;
      wdog_d.wdog_nonstop      = fetch_word.wdog_nonstop_option;
      if (fetch_word.wdog_autostart_option && POWERUP_RESET) begin
        wdog_d.wdog_enable     = 1'b1;
        wdog_d.wdog_idle_count = fetch_word.wdog_idle_option;
        wdog_d.wdog_prescale   = {fetch_word.wdog_prescale_opt2, fetch_word.wdog_prescale_opt1,
                                  fetch_word.wdog_prescale_opt0};
      end
    end else if (reg_write && addr_q == OFFS_WDOG_CTRL) begin
      // the enable is set-only so a running watchdog cannot be stopped
      wdog_d.wdog_enable = wdog_q.wdog_enable | HWDATA[6];
      if (!opt_q.wdog_write_protect_option) begin
        wdog_d.wdog_reset_enable = HWDATA[5];
        wdog_d.wdog_nonstop      = HWDATA[4];
        wdog_d.wdog_idle_count   = HWDATA[3];
        wdog_d.wdog_prescale     = HWDATA[2:0];
      end
      if (!HWDATA[7]) begin
        wdog_d.wdog_overflow_flag = 1'b0;
      end
    end else if (reg_write && addr_q == OFFS_POWER_CONTROL_THREE) begin
      debug_d = HWDATA[DEBUG_PIN_ENABLE_BIT];
    end
    // an overflow in the clearing cycle is kept
    if (WDOG_OVERFLOW) begin
      wdog_d.wdog_overflow_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wdog_q    <= WDOG_CTRL_RESET;
      debug_q   <= DEBUG_PIN_ENABLE_RESET;
      bod_req_q <= 1'b0;
      prog_q    <= PROG_LOCK_VALUE;
    end else begin
      wdog_q    <= wdog_d;
      debug_q   <= debug_d;
      bod_req_q <= bod_req_d;
      prog_q    <= prog_d;
    end
  end

  // bus slave: writes take no wait state, reads one so read data comes from a flop
  assign reg_write = wr_phase_q;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (addr_q == OFFS_OPTION_STATUS) begin
      rd_value = {8'h00, opt_q};
    end else if (addr_q == OFFS_WDOG_CTRL) begin
      rd_value = {24'h00_0000, wdog_q};
    end else if (addr_q == OFFS_POWER_CONTROL_THREE) begin
      rd_value = {31'h0000_0000, debug_q};
    end else if (addr_q == OFFS_APP_PROG_LOWER_BOUND) begin
      rd_value = {16'h0000, app_lb_q};
    end else if (addr_q == OFFS_BOOT_STATUS) begin
      rd_value = {loader_start_q, 13'h0000, por_q, boot_q, load_done_q};
    end
  end

  always_comb begin
    wr_phase_d = 1'b0;
    rd_phase_d = 1'b0;
    addr_d     = addr_q;
    hrdata_d   = hrdata_q;
    if (rd_phase_q) begin
      hrdata_d = rd_value;
    end else if (HSEL && HTRANS[1] && HREADY) begin
      addr_d     = HADDR;
      wr_phase_d = HWRITE;
      rd_phase_d = !HWRITE;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_phase_q <= 1'b0;
      rd_phase_q <= 1'b0;
      addr_q     <= 32'h0000_0000;
      hrdata_q   <= 32'h0000_0000;
    end else begin
      wr_phase_q <= wr_phase_d;
      rd_phase_q <= rd_phase_d;
      addr_q     <= addr_d;
      hrdata_q   <= hrdata_d;
    end
  end

  assign HREADYOUT            = !rd_phase_q;
  assign HRDATA               = hrdata_q;
  assign HRESP                = 1'b0;
  assign PGM_READ_DATA        = prog_q;
  assign CPU_HOLD             = !load_done_q;
  assign BOOT_FROM_LOADER     = boot_q;
  assign BOOT_START_ADDR      = boot_addr_q;
  assign LOADER_START_ADDR    = loader_start_q;
  assign APP_PROG_LOWER_BOUND = app_lb_q;
  assign BOD_SECOND_LEVEL     = {opt_q.bod_level_sel_hi, opt_q.bod_level_sel_lo};
  assign BROWNOUT_RESET_REQ   = bod_req_q;
  assign WATCHDOG_CONTROL_REG = wdog_q;
  assign DEBUG_PIN_ENABLE     = debug_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_lock_read;
    opt_q.lock |=> PGM_READ_DATA == PROG_LOCK_VALUE;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("locked read not forced");

  property p_loader_top;
    load_done_q && opt_q.loader_size != LOADER_SIZE_NONE |->
      LOADER_START_ADDR + 16'({12'h000, {1'b0, opt_q.loader_size} + 4'h1} << HALF_K_SHIFT) == 16'h8000;
  endproperty
  a_loader_top: assert property (p_loader_top) else $error("loader region does not end at flash end");

  property p_boot_choice;
    $rose(load_done_q) |-> BOOT_FROM_LOADER == (opt_q.loader_size != LOADER_SIZE_NONE &&
      !$past(BROWNOUT_RESET_CAUSE) && (opt_q.anyreset_boot_select || (opt_q.powerup_boot_select && por_q)));
  endproperty
  a_boot_choice: assert property (p_boot_choice) else $error("wrong boot source");

  property p_bod_reset;
    load_done_q && bod_sync[1] && opt_q.second_brownout_reset_en |=> BROWNOUT_RESET_REQ;
  endproperty
  a_bod_reset: assert property (p_bod_reset) else $error("second brown-out reset missing");

  property p_bod_quiet;
    !opt_q.first_brownout_reset_en && !opt_q.second_brownout_reset_en && $stable(opt_q) |=> !BROWNOUT_RESET_REQ;
  endproperty
  a_bod_quiet: assert property (p_bod_quiet) else $error("brown-out reset while disabled");

  property p_wdog_load;
    $rose(load_done_q) |-> WATCHDOG_CONTROL_REG.wdog_reset_enable == opt_q.wdog_reset_option &&
      WATCHDOG_CONTROL_REG.wdog_nonstop == opt_q.wdog_nonstop_option &&
      WATCHDOG_CONTROL_REG.wdog_enable == (opt_q.wdog_autostart_option && por_q);
  endproperty
  a_wdog_load: assert property (p_wdog_load) else $error("watchdog options not applied");

  property p_wdog_protect;
    reg_write && addr_q == OFFS_WDOG_CTRL && opt_q.wdog_write_protect_option && load_done_q
      |=> WATCHDOG_CONTROL_REG[5:0] == $past(WATCHDOG_CONTROL_REG[5:0]);
  endproperty
  a_wdog_protect: assert property (p_wdog_protect) else $error("protected watchdog bits changed");

  property p_debug_switch;
    reg_write && addr_q == OFFS_POWER_CONTROL_THREE && load_done_q |=> DEBUG_PIN_ENABLE == $past(HWDATA[0]);
  endproperty
  a_debug_switch: assert property (p_debug_switch) else $error("debug pin switch not taken");

  sequence s_read_wait;
    !HREADYOUT ##1 HREADYOUT && HRDATA == $past(rd_value);
  endsequence
  property p_read_answer;
    HSEL && HTRANS[1] && HREADY && !HWRITE |=> s_read_wait;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer out of step");

  property p_hold_until_load;
    !fetch_valid |-> CPU_HOLD;
  endproperty
  a_hold_until_load: assert property (p_hold_until_load) else $error("cpu released before options loaded");
endmodule : hardware_option_loader

//--- core/option_fetch.sv
`timescale 1ns/1ps
module option_fetch
  import hw_option_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    nvm_rd_ack,
  input  wire logic [OPTION_WIDTH-1:0] nvm_rd_data,
  input  wire logic                    nvm_erased,
  output logic                         nvm_rd_req,
  output logic                         word_valid,
  output option_type                   word
);
  fetch_state_type state_q;
  fetch_state_type state_d;
  option_type      word_q;
  option_type      word_d;

  always_comb begin
    state_d = state_q;
    word_d  = word_q;
    case (state_q)
      FETCH_REQ: begin
        state_d = FETCH_WAIT;
      end
      FETCH_WAIT: begin
        if (nvm_rd_ack) begin
          // an erased array reads as every option off, no regions
          word_d  = nvm_erased ? option_type'('0) : option_type'(nvm_rd_data);
          state_d = FETCH_DONE;
        end
      end
      default: begin
        state_d = FETCH_DONE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= FETCH_REQ;
      word_q  <= FACTORY_OPTIONS;
    end else begin
      state_q <= state_d;
      word_q  <= word_d;
    end
  end

  assign nvm_rd_req = (state_q == FETCH_WAIT);
  assign word_valid = (state_q == FETCH_DONE);
  assign word       = word_q;

  property p_erase_clears;
    @(posedge clk) disable iff (!rst_b)
      (nvm_rd_req && nvm_rd_ack && nvm_erased) |=> (word_q == option_type'('0)) && word_valid;
  endproperty
  a_erase_clears: assert property (p_erase_clears) else $error("erased array did not clear options");
endmodule : option_fetch
